// file: core/ea_decode_pkg.sv
// Shared constants, encodings and carrier types for the decode stage
package ea_decode_pkg;

    localparam int unsigned WORD_W      = 32;
    localparam int unsigned INSN_W      = 16;
    localparam int unsigned REG_NUM_W   = 4;

    // Field positions inside a 16-bit instruction word
    localparam int unsigned HI_FIELD_LSB  = 8;
    localparam int unsigned MID_FIELD_LSB = 4;
    localparam int unsigned LO_FIELD_LSB  = 0;
    localparam int unsigned DISP4_W       = 4;
    localparam int unsigned DISP8_W       = 8;
    localparam int unsigned DISP12_W      = 12;

    // Opcode masks: register and literal fields cleared, opcode bits kept
    localparam logic [15:0] MASK_ALL_OP   = 16'hFFFF;
    localparam logic [15:0] MASK_HI_REG   = 16'hF0FF;
    localparam logic [15:0] MASK_HI_MID   = 16'hF00F;
    localparam logic [15:0] MASK_MID_LO   = 16'hFF00;
    localparam logic [15:0] MASK_LOW_BYTE = 16'hFF00;
    localparam logic [15:0] MASK_LOW_12   = 16'hF000;
    localparam logic [15:0] MASK_HI_BYTE  = 16'hF000;
    localparam logic [15:0] MASK_NMD      = 16'hF000;

    // Longword PC-relative base alignment
    localparam logic [31:0] PC_LONG_MASK  = 32'hFFFF_FFFC;

    // Operand size steps in bytes
    localparam logic [31:0] STEP_BYTE     = 32'h0000_0001;
    localparam logic [31:0] STEP_WORD     = 32'h0000_0002;
    localparam logic [31:0] STEP_LONG     = 32'h0000_0004;

    // Scale shifts: x1, x2, x4
    localparam int unsigned SHIFT_BYTE    = 0;
    localparam int unsigned SHIFT_WORD    = 1;
    localparam int unsigned SHIFT_LONG    = 2;

    typedef enum logic [3:0] {
        FMT_ZERO = 4'h0,
        FMT_N    = 4'h1,
        FMT_M    = 4'h2,
        FMT_NM   = 4'h3,
        FMT_MD   = 4'h4,
        FMT_ND4  = 4'h5,
        FMT_NMD  = 4'h6,
        FMT_D    = 4'h7,
        FMT_D12  = 4'h8,
        FMT_ND8  = 4'h9,
        FMT_I    = 4'hA,
        FMT_NI   = 4'hB
    } format_type;

    typedef enum logic [3:0] {
        EA_NONE        = 4'h0,
        EA_GBR_INDEXED = 4'h1,
        EA_PC_DISP     = 4'h2,
        EA_BRANCH8     = 4'h3,
        EA_BRANCH12    = 4'h4,
        EA_BRANCH_REG  = 4'h5,
        EA_REG_DISP_S  = 4'h6,
        EA_REG_DISP_D  = 4'h7,
        EA_REG_INDEXED = 4'h8,
        EA_POSTINC     = 4'h9,
        EA_MAC         = 4'hA
    } ea_mode_type;

    typedef enum logic [1:0] {
        SIZE_BYTE = 2'b00,
        SIZE_WORD = 2'b01,
        SIZE_LONG = 2'b10
    } size_type;

    typedef enum logic [1:0] {
        IMM_NONE  = 2'b00,
        IMM_ZEXT  = 2'b01,
        IMM_SEXT  = 2'b10,
        IMM_TRAP  = 2'b11
    } imm_kind_type;

    typedef struct packed {
        logic         valid;
        logic [15:0]  word;
        format_type   fmt;
        ea_mode_type  mode;
        size_type     size;
        imm_kind_type imm_kind;
    } decode_req_type;

    typedef struct packed {
        logic [31:0] pc;
        logic [31:0] global_base_register;
        logic [31:0] index_register_zero;
        logic [31:0] source_register;
        logic [31:0] destination_register;
    } operand_type;

    typedef struct packed {
        logic        valid;
        logic [15:0] opcode;
        logic [3:0]  destination_num;
        logic [3:0]  source_num;
        logic        destination_used;
        logic        source_used;
        logic [31:0] ea;
        logic [31:0] ea_second;
        logic [31:0] imm;
        logic [31:0] source_ptr_next;
        logic [31:0] destination_ptr_next;
        logic        source_ptr_write;
        logic        destination_ptr_write;
        logic        accumulate_write;
    } decode_res_type;

endpackage

// file: core/ea_gen_and_format_decode.sv
// Effective address generation and 16-bit instruction field decode
// How it works
// - Indexed base mode: address is global base register plus index register zero.
// - PC offset: zero-extend 8-bit field, scale x2 word or x4 long, add PC.
// - Longword PC offset loads clear the two low PC bits before adding.
// - Short branch: sign-extend 8-bit field, double it, add to PC.
// - Long branch: sign-extend 12-bit field, double it, add to PC.
// - Register branch: add whole selected register to PC, no scaling.
// - Literal for bit-test, AND, OR, XOR is zero-extended.
// - Literal for move, ADD, compare-equal is sign-extended.
// - Software trap literal is zero-extended and multiplied by four.
// - Single-destination format: register in bits 11..8, all else opcode.
// - Single-source format: register branch uses source number from bits 11..8.
// - Two-register format: destination 11..8, source 7..4, remaining bits opcode.
// - Two-register stores address destination register plus index register zero.
// - Multiply-accumulate reads through two post-incremented pointers into accumulators.
// - Multiply-accumulate treats destination field as second source pointer.
// - Register-offset load: source register plus 4-bit offset in bits 3..0.
// - 4-bit offset zero-extended, scaled by 1, 2 or 4 per size.
// - Post-increment adds 1, 2 or 4 to the pointer after access.
`timescale 1ns/1ps

module ea_gen_and_format_decode
    import ea_decode_pkg::*;
(
    input  wire logic           clk_in,     // Core clock, 250 MHz
    input  wire logic           rst_in,     // Asynchronous reset, active high
    input  wire decode_req_type req_in,     // Instruction word and decode class
    input  wire operand_type    operand_in, // Register file read values
    output decode_res_type      res_out     // Registered result for execute
);

    logic [3:0]     field_hi;
    logic [3:0]     field_mid;
    logic [3:0]     field_lo;
    logic [7:0]     field_byte;
    logic [11:0]    field_12;
    logic [31:0]    step;
    logic [31:0]    disp4_scaled;
    logic [31:0]    disp8_scaled;
    logic [31:0]    pc_base;
    logic [31:0]    branch8_off;
    logic [31:0]    branch12_off;
    decode_res_type next_res;

    assign field_hi   = req_in.word[HI_FIELD_LSB +: REG_NUM_W];
    assign field_mid  = req_in.word[MID_FIELD_LSB +: REG_NUM_W];
    assign field_lo   = req_in.word[LO_FIELD_LSB +: DISP4_W];
    assign field_byte = req_in.word[LO_FIELD_LSB +: DISP8_W];
    assign field_12   = req_in.word[LO_FIELD_LSB +: DISP12_W];

    // Size step is the post-increment amount; offsets scale by separate shifts
    always_comb begin
        case (req_in.size)
            SIZE_WORD: step = STEP_WORD;
            SIZE_LONG: step = STEP_LONG;
            default:   step = STEP_BYTE;
        endcase
    end

    always_comb begin
        case (req_in.size)
            SIZE_WORD: disp4_scaled = {28'h000_0000, field_lo} << SHIFT_WORD;
            SIZE_LONG: disp4_scaled = {28'h000_0000, field_lo} << SHIFT_LONG;
            default:   disp4_scaled = {28'h000_0000, field_lo} << SHIFT_BYTE;
        endcase
    end

    // PC offset has no byte form; anything but longword scales as word
    always_comb begin
        if (req_in.size == SIZE_LONG) begin
            disp8_scaled = {24'h00_0000, field_byte} << SHIFT_LONG;
            pc_base      = operand_in.pc & PC_LONG_MASK;
        end else begin
            disp8_scaled = {24'h00_0000, field_byte} << SHIFT_WORD;
            pc_base      = operand_in.pc;
        end
    end

    assign branch8_off  = {{23{field_byte[7]}}, field_byte, 1'b0};
    assign branch12_off = {{19{field_12[11]}}, field_12, 1'b0};

    // Field split per format class
    always_comb begin
        next_res                  = '0;
        next_res.valid            = req_in.valid;
        case (req_in.fmt)
            FMT_N: begin
                next_res.destination_num  = field_hi;
                next_res.destination_used = 1'b1;
                next_res.opcode           = req_in.word & MASK_HI_REG;
            end
            FMT_M: begin
                next_res.source_num  = field_hi;
                next_res.source_used = 1'b1;
                next_res.opcode      = req_in.word & MASK_HI_REG;
            end
            FMT_NM: begin
                next_res.destination_num  = field_hi;
                next_res.source_num       = field_mid;
                next_res.destination_used = 1'b1;
                next_res.source_used      = 1'b1;
                next_res.opcode           = req_in.word & MASK_HI_MID;
            end
            FMT_MD: begin
                next_res.source_num  = field_mid;
                next_res.source_used = 1'b1;
                next_res.opcode      = req_in.word & MASK_MID_LO;
            end
            FMT_ND4: begin
                next_res.destination_num  = field_mid;
                next_res.destination_used = 1'b1;
                next_res.opcode           = req_in.word & MASK_MID_LO;
            end
            FMT_NMD: begin
                next_res.destination_num  = field_hi;
                next_res.source_num       = field_mid;
                next_res.destination_used = 1'b1;
                next_res.source_used      = 1'b1;
                next_res.opcode           = req_in.word & MASK_NMD;
            end
            FMT_D, FMT_I: begin
                next_res.opcode = req_in.word & MASK_LOW_BYTE;
            end
            FMT_D12: begin
                next_res.opcode = req_in.word & MASK_LOW_12;
            end
            FMT_ND8, FMT_NI: begin
                next_res.destination_num  = field_hi;
                next_res.destination_used = 1'b1;
                next_res.opcode           = req_in.word & MASK_HI_BYTE;
            end
            default: begin
                next_res.opcode = req_in.word & MASK_ALL_OP;
            end
        endcase

        case (req_in.imm_kind)
            IMM_ZEXT: next_res.imm = {24'h00_0000, field_byte};
            IMM_SEXT: next_res.imm = {{24{field_byte[7]}}, field_byte};
            IMM_TRAP: next_res.imm = {22'h00_0000, field_byte, 2'b00};
            default:  next_res.imm = '0;
        endcase

        // All address arithmetic settles inside the decode cycle
        case (req_in.mode)
            EA_GBR_INDEXED: begin
                next_res.ea = operand_in.global_base_register
                            + operand_in.index_register_zero;
            end
            EA_PC_DISP: begin
                next_res.ea = pc_base + disp8_scaled;
            end
            EA_BRANCH8: begin
                next_res.ea = operand_in.pc + branch8_off;
            end
            EA_BRANCH12: begin
                next_res.ea = operand_in.pc + branch12_off;
            end
            EA_BRANCH_REG: begin
                next_res.ea = operand_in.pc + operand_in.source_register;
            end
            EA_REG_DISP_S: begin
                next_res.ea = operand_in.source_register + disp4_scaled;
            end
            EA_REG_DISP_D: begin
                next_res.ea = operand_in.destination_register + disp4_scaled;
            end
            EA_REG_INDEXED: begin
                next_res.ea = operand_in.destination_register
                            + operand_in.index_register_zero;
            end
            EA_POSTINC: begin
                next_res.ea               = operand_in.source_register;
                next_res.source_ptr_next  = operand_in.source_register + step;
                next_res.source_ptr_write = req_in.valid;
            end
            EA_MAC: begin
                // Destination field is a second read pointer, post-incremented like the source
                next_res.ea                    = operand_in.source_register;
                next_res.ea_second             = operand_in.destination_register;
                next_res.source_ptr_next       = operand_in.source_register + step;
                next_res.destination_ptr_next  = operand_in.destination_register + step;
                next_res.source_ptr_write      = req_in.valid;
                next_res.destination_ptr_write = req_in.valid;
                next_res.accumulate_write      = req_in.valid;
                next_res.destination_used      = 1'b0;
            end
            default: begin
                next_res.ea = '0;
            end
        endcase
    end

    // Stage register between decode and execute
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            res_out <= '0;
        end else begin
            res_out <= next_res;
        end
    end

    // Checks
    property p_gbr_indexed;
        @(posedge clk_in) disable iff (rst_in)
        (req_in.valid && req_in.mode == EA_GBR_INDEXED) |=>
            res_out.ea == $past(operand_in.global_base_register)
                        + $past(operand_in.index_register_zero);
    endproperty
    a_gbr_indexed: assert property (p_gbr_indexed)
        else $error("indexed base address wrong");

    property p_pc_disp_word;
        @(posedge clk_in) disable iff (rst_in)
        (req_in.valid && req_in.mode == EA_PC_DISP && req_in.size == SIZE_WORD) |=>
            res_out.ea == $past(operand_in.pc) + {23'h00_0000, $past(field_byte), 1'b0};
    endproperty
    a_pc_disp_word: assert property (p_pc_disp_word)
        else $error("word PC offset address wrong");

    property p_pc_disp_long;
        @(posedge clk_in) disable iff (rst_in)
        (req_in.valid && req_in.mode == EA_PC_DISP && req_in.size == SIZE_LONG) |=>
            (res_out.ea[1:0] == 2'b00) &&
            (res_out.ea == {$past(operand_in.pc[31:2]), 2'b00}
                         + {22'h00_0000, $past(field_byte), 2'b00});
    endproperty
    a_pc_disp_long: assert property (p_pc_disp_long)
        else $error("longword PC offset address wrong");

    property p_branch8;
        @(posedge clk_in) disable iff (rst_in)
        (req_in.valid && req_in.mode == EA_BRANCH8) |=>
            res_out.ea == $past(operand_in.pc)
                        + 32'($signed($past(field_byte))) * 32'sd2;
    endproperty
    a_branch8: assert property (p_branch8)
        else $error("short branch target wrong");

    property p_branch12;
        @(posedge clk_in) disable iff (rst_in)
        (req_in.valid && req_in.mode == EA_BRANCH12) |=>
            res_out.ea == $past(operand_in.pc)
                        + 32'($signed($past(field_12))) * 32'sd2;
    endproperty
    a_branch12: assert property (p_branch12)
        else $error("long branch target wrong");

    property p_branch_reg;
        @(posedge clk_in) disable iff (rst_in)
        (req_in.valid && req_in.mode == EA_BRANCH_REG && req_in.fmt == FMT_M) |=>
            (res_out.ea == $past(operand_in.pc) + $past(operand_in.source_register))
            && (res_out.source_num == $past(req_in.word[11:8]));
    endproperty
    a_branch_reg: assert property (p_branch_reg)
        else $error("register branch target wrong");

    property p_imm_kinds;
        @(posedge clk_in) disable iff (rst_in)
        req_in.valid |=>
            ($past(req_in.imm_kind) == IMM_ZEXT -> res_out.imm[31:8] == 24'h00_0000) &&
            ($past(req_in.imm_kind) == IMM_SEXT -> res_out.imm[31:8] == {24{res_out.imm[7]}})
            && ($past(req_in.imm_kind) == IMM_TRAP ->
                res_out.imm == {22'h00_0000, $past(field_byte), 2'b00});
    endproperty
    a_imm_kinds: assert property (p_imm_kinds)
        else $error("literal extension wrong");

    property p_two_reg_fields;
        @(posedge clk_in) disable iff (rst_in)
        (req_in.valid && req_in.fmt == FMT_NM && req_in.mode != EA_MAC) |=>
            res_out.destination_num == $past(req_in.word[11:8]) &&
            res_out.source_num == $past(req_in.word[7:4]) &&
            res_out.opcode[11:4] == 8'h00;
    endproperty
    a_two_reg_fields: assert property (p_two_reg_fields)
        else $error("two-register field split wrong");

    property p_mac_pointers;
        @(posedge clk_in) disable iff (rst_in)
        (req_in.valid && req_in.mode == EA_MAC && req_in.size == SIZE_WORD) |=>
            res_out.accumulate_write && !res_out.destination_used &&
            res_out.source_ptr_next == $past(operand_in.source_register) + STEP_WORD &&
            res_out.destination_ptr_next == $past(operand_in.destination_register) + STEP_WORD;
    endproperty
    a_mac_pointers: assert property (p_mac_pointers)
        else $error("multiply-accumulate pointers wrong");

    property p_reg_disp_src;
        @(posedge clk_in) disable iff (rst_in)
        (req_in.valid && req_in.mode == EA_REG_DISP_S && req_in.size == SIZE_LONG) |=>
            res_out.ea == $past(operand_in.source_register)
                        + {26'h000_0000, $past(field_lo), 2'b00};
    endproperty
    a_reg_disp_src: assert property (p_reg_disp_src)
        else $error("register offset address wrong");

    property p_postinc_byte;
        @(posedge clk_in) disable iff (rst_in)
        (req_in.valid && req_in.mode == EA_POSTINC && req_in.size == SIZE_BYTE) |=>
            res_out.source_ptr_write &&
            res_out.source_ptr_next == res_out.ea + STEP_BYTE;
    endproperty
    a_postinc_byte: assert property (p_postinc_byte)
        else $error("post-increment step wrong");

    property p_reg_indexed;
        @(posedge clk_in) disable iff (rst_in)
        (req_in.valid && req_in.mode == EA_REG_INDEXED) |=>
            res_out.ea == $past(operand_in.destination_register)
                        + $past(operand_in.index_register_zero);
    endproperty
    a_reg_indexed: assert property (p_reg_indexed)
        else $error("indexed register address wrong");

    property p_single_dest;
        @(posedge clk_in) disable iff (rst_in)
        (req_in.valid && req_in.fmt == FMT_N) |=>
            res_out.destination_num == $past(req_in.word[11:8]) &&
            res_out.opcode == {$past(req_in.word[15:12]), 4'h0, $past(req_in.word[7:0])};
    endproperty
    a_single_dest: assert property (p_single_dest)
        else $error("single-destination field split wrong");

    // Store form bases on the destination pointer, not the source
    property p_reg_disp_dst;
        @(posedge clk_in) disable iff (rst_in)
        (req_in.valid && req_in.mode == EA_REG_DISP_D && req_in.size == SIZE_WORD) |=>
            res_out.ea == $past(operand_in.destination_register)
                        + {27'h000_0000, $past(field_lo), 1'b0};
    endproperty
    a_reg_disp_dst: assert property (p_reg_disp_dst)
        else $error("destination register offset address wrong");

    property p_sext_literal;
        @(posedge clk_in) disable iff (rst_in)
        (req_in.valid && req_in.imm_kind == IMM_SEXT) |=>
            res_out.imm == {{24{$past(field_byte[7])}}, $past(field_byte)};
    endproperty
    a_sext_literal: assert property (p_sext_literal)
        else $error("sign-extended literal wrong");

    c_mac: cover property (@(posedge clk_in) disable iff (rst_in)
        req_in.valid && req_in.mode == EA_MAC);
    c_branch12_back: cover property (@(posedge clk_in) disable iff (rst_in)
        req_in.valid && req_in.mode == EA_BRANCH12 && field_12[11]);
    c_pc_long: cover property (@(posedge clk_in) disable iff (rst_in)
        req_in.valid && req_in.mode == EA_PC_DISP && req_in.size == SIZE_LONG);
    c_trap: cover property (@(posedge clk_in) disable iff (rst_in)
        req_in.valid && req_in.imm_kind == IMM_TRAP);
    c_reg_disp_dst: cover property (@(posedge clk_in) disable iff (rst_in)
        req_in.valid && req_in.mode == EA_REG_DISP_D);

endmodule

// file: bench/ea_gen_and_format_decode_bench.sv
// Self-checking bench for the address generation and field decode block
`timescale 1ns/1ps

`define CHK(got, exp) begin num_checks++; if ((got) !== (exp)) begin n_fail++; \
    $display("BAD t=%0t got=%h exp=%h", $time, (got), (exp)); end end

module ea_gen_and_format_decode_bench;
    import ea_decode_pkg::*;

    logic           clk_in;
    logic           rst_in;
    decode_req_type req_in;
    operand_type    operand_in;
    decode_res_type res_out;
    int             n_fail;
    int             num_checks;

    ea_gen_and_format_decode u_dut (
        .clk_in     (clk_in),
        .rst_in     (rst_in),
        .req_in     (req_in),
        .operand_in (operand_in),
        .res_out    (res_out)
    );

    initial begin
        clk_in = 1'b0;
        forever #2 clk_in = ~clk_in;
    end

    task automatic stop_test();
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // Called at posedge+1; result is checked one edge later
    task automatic issue(input logic [15:0] w, input format_type f, input ea_mode_type m,
                         input size_type s, input imm_kind_type k);
        req_in = '{valid: 1'b1, word: w, fmt: f, mode: m, size: s, imm_kind: k};
        @(posedge clk_in);
        #1;
    endtask

    task automatic t_gbr();
        operand_in.global_base_register = 32'h1000_0000;
        operand_in.index_register_zero  = 32'hFFFF_FFFC;
        issue(16'hCC00, FMT_ZERO, EA_GBR_INDEXED, SIZE_BYTE, IMM_NONE);
        `CHK(res_out.ea, 32'h0FFF_FFFC)
        `CHK(res_out.valid, 1'b1)
        $display("test gbr done");
    endtask

    task automatic t_pc_disp();
        operand_in.pc = 32'h0000_1003;
        issue(16'hC7FF, FMT_D, EA_PC_DISP, SIZE_WORD, IMM_NONE);
        `CHK(res_out.ea, 32'h0000_1201)
        issue(16'hD3FF, FMT_ND8, EA_PC_DISP, SIZE_LONG, IMM_NONE);
        `CHK(res_out.ea, 32'h0000_13FC)
        `CHK(res_out.destination_num, 4'h3)
        $display("test pc offset done");
    endtask

    task automatic t_branch();
        operand_in.pc = 32'h0000_1000;
        issue(16'h8980, FMT_D, EA_BRANCH8, SIZE_WORD, IMM_NONE);
        `CHK(res_out.ea, 32'h0000_0F00)
        issue(16'h897F, FMT_D, EA_BRANCH8, SIZE_WORD, IMM_NONE);
        `CHK(res_out.ea, 32'h0000_10FE)
        operand_in.pc = 32'h0000_2000;
        issue(16'hA800, FMT_D12, EA_BRANCH12, SIZE_WORD, IMM_NONE);
        `CHK(res_out.ea, 32'h0000_1000)
        issue(16'hA7FF, FMT_D12, EA_BRANCH12, SIZE_WORD, IMM_NONE);
        `CHK(res_out.ea, 32'h0000_2FFE)
        operand_in.pc              = 32'h0000_0100;
        operand_in.source_register = 32'hFFFF_FFF0;
        issue(16'h0523, FMT_M, EA_BRANCH_REG, SIZE_LONG, IMM_NONE);
        `CHK(res_out.ea, 32'h0000_00F0)
        `CHK(res_out.source_num, 4'h5)
        $display("test branch done");
    endtask

    task automatic t_imm();
        imm_kind_type kinds [4];
        logic [31:0]  exp_v [4];
        kinds = '{IMM_ZEXT, IMM_SEXT, IMM_TRAP, IMM_NONE};
        exp_v = '{32'h0000_0080, 32'hFFFF_FF80, 32'h0000_0200, 32'h0000_0000};
        for (int i = 0; i < 4; i++) begin
            issue(16'hC880, FMT_I, EA_NONE, SIZE_BYTE, kinds[i]);
            `CHK(res_out.imm, exp_v[i])
            `CHK(res_out.ea, 32'h0000_0000)
        end
        issue(16'h7A7F, FMT_NI, EA_NONE, SIZE_BYTE, IMM_SEXT);
        `CHK(res_out.imm, 32'h0000_007F)
        `CHK(res_out.destination_num, 4'hA)
        $display("test literal done");
    endtask

    task automatic t_fields();
        size_type    sz    [3];
        logic [31:0] exp_v [3];
        sz    = '{SIZE_BYTE, SIZE_WORD, SIZE_LONG};
        exp_v = '{32'h0000_0109, 32'h0000_0112, 32'h0000_0124};
        issue(16'h4A2B, FMT_N, EA_NONE, SIZE_LONG, IMM_NONE);
        `CHK(res_out.destination_num, 4'hA)
        `CHK(res_out.opcode, 16'h402B)
        `CHK({res_out.destination_used, res_out.source_used}, 2'b10)
        issue(16'h6C7E, FMT_NM, EA_NONE, SIZE_LONG, IMM_NONE);
        `CHK(res_out.destination_num, 4'hC)
        `CHK(res_out.source_num, 4'h7)
        `CHK(res_out.opcode, 16'h600E)
        `CHK({res_out.destination_used, res_out.source_used}, 2'b11)
        operand_in.source_register = 32'h0000_0100;
        for (int i = 0; i < 3; i++) begin
            issue(16'h8539, FMT_MD, EA_REG_DISP_S, sz[i], IMM_NONE);
            `CHK(res_out.ea, exp_v[i])
            `CHK(res_out.source_num, 4'h3)
        end
        operand_in.destination_register = 32'h8000_0000;
        operand_in.index_register_zero  = 32'h0000_0044;
        issue(16'h0B64, FMT_NM, EA_REG_INDEXED, SIZE_LONG, IMM_NONE);
        `CHK(res_out.ea, 32'h8000_0044)
        `CHK(res_out.destination_num, 4'hB)
        $display("test fields done");
    endtask

    task automatic t_mac();
        operand_in.source_register      = 32'h0000_2000;
        operand_in.destination_register = 32'h0000_3FFE;
        issue(16'h4B5F, FMT_NM, EA_MAC, SIZE_WORD, IMM_NONE);
        `CHK(res_out.ea, 32'h0000_2000)
        `CHK(res_out.ea_second, 32'h0000_3FFE)
        `CHK(res_out.source_ptr_next, 32'h0000_2002)
        `CHK(res_out.destination_ptr_next, 32'h0000_4000)
        `CHK({res_out.source_ptr_write, res_out.destination_ptr_write}, 2'b11)
        `CHK(res_out.accumulate_write, 1'b1)
        `CHK(res_out.destination_used, 1'b0)
        `CHK(res_out.source_num, 4'h5)
        issue(16'h4B5F, FMT_NM, EA_MAC, SIZE_LONG, IMM_NONE);
        `CHK(res_out.source_ptr_next, 32'h0000_2004)
        `CHK(res_out.destination_ptr_next, 32'h0000_4002)
        // Idle slot right after: nothing may be written
        req_in.valid = 1'b0;
        @(posedge clk_in);
        #1;
        `CHK(res_out.valid, 1'b0)
        `CHK(res_out.accumulate_write, 1'b0)
        $display("test mac done");
    endtask

    task automatic t_store();
        operand_in.destination_register = 32'h0000_4000;
        operand_in.source_register      = 32'h0000_0010;
        issue(16'h8175, FMT_ND4, EA_REG_DISP_D, SIZE_WORD, IMM_NONE);
        `CHK(res_out.ea, 32'h0000_400A)
        `CHK(res_out.destination_num, 4'h7)
        `CHK(res_out.opcode, 16'h8100)
        issue(16'h1A3F, FMT_NMD, EA_REG_DISP_D, SIZE_LONG, IMM_NONE);
        `CHK(res_out.ea, 32'h0000_403C)
        `CHK({res_out.destination_num, res_out.source_num}, 8'hA3)
        `CHK(res_out.opcode, 16'h1000)
        issue(16'h6D46, FMT_NM, EA_POSTINC, SIZE_BYTE, IMM_NONE);
        `CHK(res_out.ea, 32'h0000_0010)
        `CHK(res_out.source_ptr_next, 32'h0000_0011)
        `CHK(res_out.source_ptr_write, 1'b1)
        issue(16'h6D46, FMT_NM, EA_POSTINC, SIZE_WORD, IMM_NONE);
        `CHK(res_out.source_ptr_next, 32'h0000_0012)
        $display("test store and post-increment done");
    endtask

    // Reset mid-run must clear the stage without waiting for a clock
    task automatic t_reset();
        issue(16'h4A2B, FMT_N, EA_NONE, SIZE_LONG, IMM_NONE);
        rst_in = 1'b1;
        #1;
        `CHK(res_out, '0)
        @(posedge clk_in);
        #1;
        rst_in = 1'b0;
        @(posedge clk_in);
        #1;
        `CHK(res_out.destination_num, 4'hA)
        $display("test reset done");
    endtask

    initial begin
        rst_in     = 1'b1;
        req_in     = '0;
        operand_in = '0;
        n_fail     = 0;
        num_checks = 0;
        repeat (2) @(posedge clk_in);
        #1;
        `CHK(res_out, '0)
        rst_in = 1'b0;
        t_gbr();
        t_pc_disp();
        t_branch();
        t_imm();
        t_fields();
        t_mac();
        t_store();
        t_reset();
        stop_test();
    end

    // Whole run is well under 100 cycles; 2000 leaves ample margin
    initial begin
        #8000;
        n_fail++;
        $display("watchdog expired");
        stop_test();
    end

endmodule
